//--- hdl/rtx_pkg.sv
package rtx_pkg;

	localparam int RTX_DATA_W   = 8;
	localparam int RTX_NIBBLE_W = 4;

	// Mode encodings
	localparam logic RTX_MODE_RGMII = 1'b0;
	localparam logic RTX_MODE_RMII  = 1'b1;

	// Dibit slots per byte in two-bit mode
	localparam logic [1:0] RTX_DIBIT_FIRST = 2'h0;
	localparam logic [1:0] RTX_DIBIT_LAST  = 2'h3;
	localparam logic [1:0] RTX_DIBIT_STEP  = 2'h1;

	// Level held on the unused upper lines in two-bit mode
	localparam logic [1:0] RTX_UNUSED_LEVEL = 2'h0;

	// Reset values
	localparam logic RTX_MODE_RESET   = RTX_MODE_RGMII;
	localparam logic RTX_SUPPLY_ON    = 1'b1;
	localparam logic RTX_SUPPLY_RESET = 1'b0;

	typedef struct packed {
		logic                  en;
		logic                  er;
		logic [RTX_DATA_W-1:0] data;
	} rtx_word_t;

	typedef struct packed {
		logic      mode;
		rtx_word_t word;
	} rtx_xfer_t;

	typedef struct packed {
		logic                    clk;
		logic                    ctl;
		logic [RTX_NIBBLE_W-1:0] data;
	} rtx_pins_t;

	localparam rtx_word_t RTX_WORD_IDLE = '{en: 1'b0, er: 1'b0, data: 8'h00};
	localparam rtx_xfer_t RTX_XFER_IDLE = '{mode: RTX_MODE_RESET, word: RTX_WORD_IDLE};
	localparam rtx_pins_t RTX_PINS_IDLE = '{clk: 1'b0, ctl: 1'b0, data: 4'h0};

	typedef enum logic [0:0] {
		RTX_LINK_IDLE = 1'b0,
		RTX_LINK_SEND = 1'b1
	} rtx_link_state_t;

endpackage

//--- hdl/rtx_word_cdc.sv
`timescale 1ns/1ps
module rtx_word_cdc
	import rtx_pkg::*;
(
	input  wire logic            src_clock,
	input  wire logic            src_reset_n,
	input  wire logic            src_valid,
	output      logic            src_ready,
	input  rtx_pkg::rtx_xfer_t   src_xfer,
	input  wire logic            dst_clock,
	input  wire logic            dst_reset_n,
	output      logic            dst_valid,
	input  wire logic            dst_take,
	output rtx_pkg::rtx_xfer_t   dst_xfer
);
	logic      req_reg;
	rtx_xfer_t hold_reg;
	logic      ack_meta_reg;
	logic      ack_sync_reg;
	logic      req_meta_reg;
	logic      req_sync_reg;
	logic      ack_reg;

	// Source side: toggle request, hold word stable until acknowledged
	always_ff @(posedge src_clock) begin
		if (!src_reset_n) begin
			req_reg  <= 1'b0;
			hold_reg <= RTX_XFER_IDLE;
		end else if (src_valid && src_ready) begin
			req_reg  <= ~req_reg;
			hold_reg <= src_xfer;
		end
	end

	always_ff @(posedge src_clock) begin
		if (!src_reset_n) begin
			ack_meta_reg <= 1'b0;
			ack_sync_reg <= 1'b0;
		end else begin
			ack_meta_reg <= ack_reg;
			ack_sync_reg <= ack_meta_reg;
		end
	end

	assign src_ready = (req_reg == ack_sync_reg);

	// Destination side
	always_ff @(posedge dst_clock) begin
		if (!dst_reset_n) begin
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
		end else begin
			req_meta_reg <= req_reg;
			req_sync_reg <= req_meta_reg;
		end
	end

	always_ff @(posedge dst_clock) begin
		if (!dst_reset_n) begin
			ack_reg <= 1'b0;
		end else if (dst_take && dst_valid) begin
			ack_reg <= ~ack_reg;
		end
	end

	assign dst_valid = (req_sync_reg != ack_reg);
	assign dst_xfer  = hold_reg;

endmodule

//--- hdl/rtx_ddr_out.sv
`timescale 1ns/1ps
module rtx_ddr_out
	import rtx_pkg::*;
(
	input  wire logic          link_clock,
	input  wire logic          link_reset_n,
	input  rtx_pkg::rtx_pins_t rise_pins,
	input  rtx_pkg::rtx_pins_t fall_pins,
	output rtx_pkg::rtx_pins_t pins_out
);
	rtx_pins_t rise_reg;
	rtx_pins_t fall_hold_reg;
	rtx_pins_t fall_reg;

	// Rising-edge half and the falling half captured alongside it
	always_ff @(posedge link_clock) begin
		if (!link_reset_n) begin
			rise_reg      <= RTX_PINS_IDLE;
			fall_hold_reg <= RTX_PINS_IDLE;
		end else begin
			rise_reg      <= rise_pins;
			fall_hold_reg <= fall_pins;
		end
	end

	// Falling-edge half
	always_ff @(negedge link_clock) begin
		if (!link_reset_n) begin
			fall_reg <= RTX_PINS_IDLE;
		end else begin
			fall_reg <= fall_hold_reg;
		end
	end

	assign pins_out = link_clock ? rise_reg : fall_reg;

endmodule

//--- hdl/rtx_tx_pin_mapper.sv
// Notes on behaviour
// [RL1] The transmit clock pin carries the link clock, as transmit clock or as shared reference.
// [RL2] In RGMII the control pin shows enable on the rising half and enable xor error on the falling.
// [RL3] In RMII the control pin carries the transmit enable alone.
// [RL4] In RGMII data line n carries byte bit n on the rising half and bit n+4 on the falling.
// [RL5] In RMII lines 0 and 1 carry one dibit per reference clock, low dibit first.
// [RL6] In RMII lines 2 and 3 carry no data and stay at a constant level.
// [RL7] The mode is only taken up between frames and never changes inside one.
`timescale 1ns/1ps
module rtx_tx_pin_mapper
	import rtx_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          reset_n,
	input  wire logic          link_clock,
	input  wire logic          mode_sel_pin,
	input  wire logic          mac_tx_valid,
	output      logic          mac_tx_ready,
	input  rtx_pkg::rtx_word_t mac_tx_word,
	output      logic          mode_rmii_active,
	output      logic          link_active,
	output      logic          tx_underrun,
	output      logic          mac_xmit_clock_pin,
	output      logic          mac_xmit_control_pin,
	output      logic          mac_xmit_data_line0,
	output      logic          mac_xmit_data_line1,
	output      logic          mac_xmit_data_line2,
	output      logic          mac_xmit_data_line3,
	output      logic          mac_port_supply_out
);
	// System domain
	logic            mode_meta_reg;
	logic            mode_sync_reg;
	logic            mode_reg;
	logic            frame_reg;
	logic            busy_meta_reg;
	logic            busy_sync_reg;
	logic            urun_meta_reg;
	logic            urun_sync_reg;
	logic            urun_seen_reg;
	logic            urun_pulse_reg;
	logic            supply_reg;
	logic            src_ready;
	logic            accept;
	rtx_xfer_t       src_xfer;

	// Link domain
	logic            lrst_meta_reg;
	logic            lrst_sync_reg;
	rtx_link_state_t state_reg;
	rtx_link_state_t state_next;
	rtx_word_t       cur_reg;
	logic            lmode_reg;
	logic [1:0]      dibit_reg;
	logic            urun_tgl_reg;
	logic            dst_valid;
	logic            dst_take;
	rtx_xfer_t       dst_xfer;
	logic            slot_last;
	rtx_pins_t       rise_pins;
	rtx_pins_t       fall_pins;
	rtx_pins_t       pins_out;

	// Two-bit mode test, shared by slot count and pin map
	function automatic logic rtx_is_rmii(input logic mode);
		logic is_rmii;
		is_rmii = (mode == RTX_MODE_RMII);
		return is_rmii;
	endfunction

	// Dibit of a byte by slot number
	function automatic logic [1:0] rtx_dibit(input logic [RTX_DATA_W-1:0] data,
		input logic [1:0] idx);
		logic [1:0] sel;
		sel = 2'h0;
		case (idx)
			2'h0: sel = data[1:0];
			2'h1: sel = data[3:2];
			2'h2: sel = data[5:4];
			2'h3: sel = data[7:6];
			default: sel = 2'h0;
		endcase
		return sel;
	endfunction

	// Mode select pin synchroniser
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mode_meta_reg <= RTX_MODE_RESET;
			mode_sync_reg <= RTX_MODE_RESET;
		end else begin
			mode_meta_reg <= mode_sel_pin;
			mode_sync_reg <= mode_meta_reg;
		end
	end

	// Crossing idle means ready
	assign mac_tx_ready = src_ready;
	assign accept       = mac_tx_valid && src_ready;

	// Frame tracking on the MAC side
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			frame_reg <= 1'b0;
		end else if (accept) begin
			frame_reg <= mac_tx_word.en;
		end
	end

	// [RL7] Mode only between frames
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mode_reg <= RTX_MODE_RESET;
		end else if (!frame_reg && !accept && !busy_sync_reg) begin
			mode_reg <= mode_sync_reg;
		end
	end

	assign mode_rmii_active = mode_reg;

	// Each word travels with the mode it was accepted under
	always_comb begin
		src_xfer      = RTX_XFER_IDLE;
		src_xfer.mode = mode_reg;
		src_xfer.word = mac_tx_word;
	end

	// Link busy level back to the system domain
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busy_meta_reg <= 1'b0;
			busy_sync_reg <= 1'b0;
		end else begin
			busy_meta_reg <= (state_reg == RTX_LINK_SEND);
			busy_sync_reg <= busy_meta_reg;
		end
	end

	assign link_active = busy_sync_reg;

	// Underrun event back to the system domain
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			urun_meta_reg  <= 1'b0;
			urun_sync_reg  <= 1'b0;
			urun_seen_reg  <= 1'b0;
			urun_pulse_reg <= 1'b0;
		end else begin
			urun_meta_reg  <= urun_tgl_reg;
			urun_sync_reg  <= urun_meta_reg;
			urun_seen_reg  <= urun_sync_reg;
			urun_pulse_reg <= urun_sync_reg ^ urun_seen_reg;
		end
	end

	assign tx_underrun = urun_pulse_reg;

	// Port supply enabled once out of reset
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			supply_reg <= RTX_SUPPLY_RESET;
		end else begin
			supply_reg <= RTX_SUPPLY_ON;
		end
	end

	assign mac_port_supply_out = supply_reg;

	// Word crossing into the link domain
	rtx_word_cdc u_word_cdc (
		.src_clock   (clock),
		.src_reset_n (reset_n),
		.src_valid   (mac_tx_valid),
		.src_ready   (src_ready),
		.src_xfer    (src_xfer),
		.dst_clock   (link_clock),
		.dst_reset_n (lrst_sync_reg),
		.dst_valid   (dst_valid),
		.dst_take    (dst_take),
		.dst_xfer    (dst_xfer)
	);

	// Reset into the link domain
	always_ff @(posedge link_clock) begin
		lrst_meta_reg <= reset_n;
		lrst_sync_reg <= lrst_meta_reg;
	end

	// [RL5] One byte per link clock in RGMII, one byte per four link clocks in RMII
	assign slot_last = rtx_is_rmii(lmode_reg) ? (dibit_reg == RTX_DIBIT_LAST) : 1'b1;
	assign dst_take  = (state_reg == RTX_LINK_IDLE) || slot_last;

	// Link frame state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RTX_LINK_IDLE: begin
				if (dst_valid && dst_xfer.word.en) begin
					state_next = RTX_LINK_SEND;
				end
			end
			RTX_LINK_SEND: begin
				if (slot_last && (!dst_valid || !dst_xfer.word.en)) begin
					state_next = RTX_LINK_IDLE;
				end
			end
			default: state_next = RTX_LINK_IDLE;
		endcase
	end

	// Link state register
	always_ff @(posedge link_clock) begin
		if (!lrst_sync_reg) begin
			state_reg <= RTX_LINK_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Current byte on the link
	always_ff @(posedge link_clock) begin
		if (!lrst_sync_reg) begin
			cur_reg <= RTX_WORD_IDLE;
		end else if (dst_take) begin
			if (dst_valid) begin
				cur_reg <= dst_xfer.word;
			end else if (state_reg == RTX_LINK_SEND) begin
				cur_reg <= RTX_WORD_IDLE;
			end
		end
	end

	// [RL7] Link mode latched only between frames, from any word taken while the link is idle
	always_ff @(posedge link_clock) begin
		if (!lrst_sync_reg) begin
			lmode_reg <= RTX_MODE_RESET;
		end else if (state_reg == RTX_LINK_IDLE && dst_valid) begin
			lmode_reg <= dst_xfer.mode;
		end
	end

	// [RL5] Dibit position within the byte
	always_ff @(posedge link_clock) begin
		if (!lrst_sync_reg) begin
			dibit_reg <= RTX_DIBIT_FIRST;
		end else if (dst_take) begin
			dibit_reg <= RTX_DIBIT_FIRST;
		end else begin
			dibit_reg <= dibit_reg + RTX_DIBIT_STEP;
		end
	end

	// Frame starved mid-byte stream ends the frame
	always_ff @(posedge link_clock) begin
		if (!lrst_sync_reg) begin
			urun_tgl_reg <= 1'b0;
		end else if (state_reg == RTX_LINK_SEND && slot_last && !dst_valid) begin
			urun_tgl_reg <= ~urun_tgl_reg;
		end
	end

	// Pin values for each half of the link clock
	always_comb begin
		rise_pins     = RTX_PINS_IDLE;
		fall_pins     = RTX_PINS_IDLE;
		// [RL1] Clock pin high half, low half
		rise_pins.clk = 1'b1;
		fall_pins.clk = 1'b0;
		if (rtx_is_rmii(lmode_reg)) begin
			// [RL3] Enable alone
			rise_pins.ctl  = cur_reg.en;
			// [RL5] Dibit on lines 0 and 1
			// [RL6] Upper lines constant
			rise_pins.data = {RTX_UNUSED_LEVEL, rtx_dibit(cur_reg.data, dibit_reg)};
			fall_pins.ctl  = rise_pins.ctl;
			fall_pins.data = rise_pins.data;
		end else begin
			// [RL2] Enable, then enable xor error
			rise_pins.ctl  = cur_reg.en;
			fall_pins.ctl  = cur_reg.en ^ cur_reg.er;
			// [RL4] Low nibble rising, high nibble falling
			rise_pins.data = cur_reg.data[3:0];
			fall_pins.data = cur_reg.data[7:4];
		end
	end

	// [RL1] Output stage on the link clock
	rtx_ddr_out u_ddr_out (
		.link_clock   (link_clock),
		.link_reset_n (lrst_sync_reg),
		.rise_pins    (rise_pins),
		.fall_pins    (fall_pins),
		.pins_out     (pins_out)
	);

	// [RL1] Clock pin from the same output stage as the data
	assign mac_xmit_clock_pin   = pins_out.clk;
	assign mac_xmit_control_pin = pins_out.ctl;
	assign mac_xmit_data_line0  = pins_out.data[0];
	assign mac_xmit_data_line1  = pins_out.data[1];
	assign mac_xmit_data_line2  = pins_out.data[2];
	assign mac_xmit_data_line3  = pins_out.data[3];

endmodule

//--- verification/rtx_tx_pin_mapper_asserts.sv
`timescale 1ns/1ps
module rtx_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic link_clock,
	input wire logic mac_tx_valid,
	input wire logic mac_tx_ready,
	input wire logic mode_rmii_active,
	input wire logic link_active,
	input wire logic tx_underrun,
	input wire logic mac_xmit_clock_pin,
	input wire logic mac_xmit_control_pin,
	input wire logic mac_xmit_data_line0,
	input wire logic mac_xmit_data_line1,
	input wire logic mac_xmit_data_line2,
	input wire logic mac_xmit_data_line3,
	input wire logic mac_port_supply_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_supply_on: assert property (disable iff (1'b0) reset_n |=> mac_port_supply_out)
		else $error("supply low after reset release");
	a_reset_idle: assert property (disable iff (1'b0) !reset_n |=> mac_tx_ready &&
		!link_active && !tx_underrun && !mode_rmii_active && !mac_port_supply_out)
		else $error("outputs not idle in reset");
	a_reset_pins: assert property (disable iff (1'b0) !reset_n [*8] |->
		!mac_xmit_clock_pin && !mac_xmit_control_pin && !mac_xmit_data_line0 &&
		!mac_xmit_data_line1 && !mac_xmit_data_line2 && !mac_xmit_data_line3)
		else $error("pins not low in reset");
	a_ready_drop: assert property (mac_tx_valid && mac_tx_ready |=> !mac_tx_ready)
		else $error("ready stayed high after accept");
	a_underrun_pulse: assert property (tx_underrun |=> !tx_underrun)
		else $error("underrun longer than one cycle");
	a_mode_frozen: assert property (
		link_active && $past(link_active) |-> $stable(mode_rmii_active))
		else $error("mode changed while link busy");
	a_clock_pin: assert property (
		link_active |-> mac_xmit_clock_pin == link_clock)
		else $error("clock pin differs from link clock");
	a_unused_low: assert property (
		mode_rmii_active && $past(mode_rmii_active, 8) |->
		!mac_xmit_data_line2 && !mac_xmit_data_line3)
		else $error("upper lines not low in two-bit mode");
endmodule

bind rtx_tx_pin_mapper rtx_chk u_chk (.clock, .reset_n, .link_clock, .mac_tx_valid,
	.mac_tx_ready, .mode_rmii_active, .link_active, .tx_underrun, .mac_xmit_clock_pin,
	.mac_xmit_control_pin, .mac_xmit_data_line0, .mac_xmit_data_line1,
	.mac_xmit_data_line2, .mac_xmit_data_line3, .mac_port_supply_out);

//--- verification/rtx_phy_model.sv
`timescale 1ns/1ps
module rtx_phy_model (
	input  wire logic       link_clock,
	input  wire logic       rmii,
	input  wire logic       txc,
	input  wire logic       ctl,
	input  wire logic       d0,
	input  wire logic       d1,
	input  wire logic       d2,
	input  wire logic       d3,
	output      logic [7:0] rx_byte,
	output      logic       rx_err,
	output      logic [7:0] rx_cnt,
	output      logic       side_bad
);
	logic [7:0] sh   = 8'h00;
	logic [3:0] lo   = 4'h0;
	logic [1:0] slot = 2'h0;
	logic       en_r = 1'b0;
	initial begin
		rx_byte = 8'h00;
		rx_err = 1'b0;
		rx_cnt = 8'h00;
		side_bad = 1'b0;
	end
	always @(posedge link_clock) begin
		#16;
		en_r = ctl;
		lo = {d3, d2, d1, d0};
		if (ctl === 1'b1 && txc !== 1'b1) side_bad = 1'b1;
		if (rmii && ctl === 1'b1) begin
			if ({d3, d2} !== 2'h0) side_bad = 1'b1;
			sh = {d1, d0, sh[7:2]};
			slot = slot + 2'h1;
			if (slot == 2'h0) begin
				rx_byte = sh;
				rx_err = 1'b0;
				rx_cnt = rx_cnt + 8'h01;
			end
		end else if (rmii) slot = 2'h0;
	end
	always @(negedge link_clock) begin
		#16;
		if (en_r === 1'b1 && txc !== 1'b0) side_bad = 1'b1;
		if (rmii && en_r === 1'b1 && {ctl, d3, d2} !== 3'h4) side_bad = 1'b1;
		if (!rmii && en_r === 1'b1) begin
			rx_byte = {d3, d2, d1, d0, lo};
			rx_err = en_r ^ ctl;
			rx_cnt = rx_cnt + 8'h01;
		end
	end
endmodule

//--- verification/rtx_tx_pin_mapper_bench.sv
`timescale 1ns/1ps
module rtx_tx_pin_mapper_bench;
	import rtx_pkg::*;
	logic       clock = 0, reset_n = 0, link_clock = 0, mode_sel_pin = 0, mac_tx_valid = 0;
	rtx_word_t  mac_tx_word = RTX_WORD_IDLE;
	logic       ready, rmii_act, lnk_act, undr, txc, ctl, d0, d1, d2, d3, supply;
	logic       phy_mode = 0, und_seen = 0, rx_err, side_bad;
	logic [7:0] rx_byte, rx_cnt;
	int         n_fail = 0, compares = 0;
	logic [9:0] rows [4] = '{10'h0A5, 10'h13C, 10'h2B4, 10'h35A};
	always #50 clock = ~clock;
	always #32 link_clock = ~link_clock;
	always @(posedge clock) if (undr === 1'b1) und_seen <= 1'b1;
	rtx_tx_pin_mapper u_dut (.clock, .reset_n, .link_clock, .mode_sel_pin, .mac_tx_valid,
		.mac_tx_ready(ready), .mac_tx_word, .mode_rmii_active(rmii_act), .link_active(lnk_act),
		.tx_underrun(undr), .mac_xmit_clock_pin(txc), .mac_xmit_control_pin(ctl),
		.mac_xmit_data_line0(d0), .mac_xmit_data_line1(d1), .mac_xmit_data_line2(d2),
		.mac_xmit_data_line3(d3), .mac_port_supply_out(supply));
	rtx_phy_model u_phy (.link_clock, .rmii(phy_mode), .txc, .ctl, .d0, .d1, .d2, .d3,
		.rx_byte, .rx_err, .rx_cnt, .side_bad);
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("fails=%0d compares=%0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic put(input logic en, input logic er, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clock);
		mac_tx_valid = 1'b1;
		mac_tx_word = '{en: en, er: er, data: d};
		while (ready !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		cmp({7'h0, n < 200}, 8'h01);
		@(negedge clock);
		mac_tx_valid = 1'b0;
	endtask
	task automatic set_mode(input logic m);
		int n;
		n = 0;
		mode_sel_pin = m;
		phy_mode = m;
		while ((rmii_act !== m || lnk_act !== 1'b0) && n < 100) begin
			@(negedge clock);
			n++;
		end
		cmp({7'h0, rmii_act}, {7'h0, m});
	endtask
	task automatic frame(input logic m, input logic er, input logic [7:0] d, input logic flip);
		logic [7:0] c;
		int         n;
		set_mode(m);
		c = rx_cnt;
		n = 0;
		put(1'b1, er, d);
		if (flip) begin
			mode_sel_pin = ~m;
			repeat (3) @(negedge clock);
			cmp({7'h0, rmii_act}, {7'h0, m});
		end
		put(1'b0, 1'b0, 8'h00);
		while ((rx_cnt === c || lnk_act !== 1'b0) && n < 300) begin
			@(negedge clock);
			n++;
		end
		cmp({7'h0, lnk_act}, 8'h00);
		cmp(rx_cnt, c + 8'h01);
		cmp(rx_byte, d);
		cmp({7'h0, rx_err}, {7'h0, er & ~m});
	endtask
	initial begin
		repeat (16) @(negedge clock);
		cmp({7'h0, supply}, 8'h00);
		reset_n = 1'b1;
		@(negedge clock);
		cmp({7'h0, supply}, 8'h01);
		for (int i = 0; i < 4; i++) frame(rows[i][9], rows[i][8], rows[i][7:0], 1'b0);
		frame(1'b1, 1'b0, 8'hC3, 1'b1);
		set_mode(1'b0);
		und_seen = 1'b0;
		put(1'b1, 1'b0, 8'h11);
		put(1'b1, 1'b0, 8'h22);
		put(1'b0, 1'b0, 8'h00);
		repeat (40) @(negedge clock);
		cmp({7'h0, und_seen}, 8'h01);
		reset_n = 1'b0;
		repeat (16) @(negedge clock);
		cmp({7'h0, supply}, 8'h00);
		cmp({7'h0, ready}, 8'h01);
		cmp({2'h0, txc, ctl, d3, d2, d1, d0}, 8'h00);
		reset_n = 1'b1;
		@(negedge clock);
		cmp({7'h0, supply}, 8'h01);
		frame(1'b0, 1'b1, 8'h96, 1'b0);
		cmp({7'h0, side_bad}, 8'h00);
		wrap_up();
	end
	initial begin
		#3000000;
		cmp(8'h00, 8'h01);
		wrap_up();
	end
endmodule
